// [ocfd_pkg.sv]
// shared constants and types for the output channel fault diagnostics block
package ocfd_pkg;
  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [3:0] OCFD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] OCFD_ADDR_FAULT = 4'h1;
  localparam logic [3:0] OCFD_ADDR_STATUS = 4'h2;
  localparam logic [3:0] OCFD_ADDR_RETRY = 4'h3;

  // control register fields
  localparam int OCFD_CTRL_TB_LO = 0;
  localparam int OCFD_CTRL_TB_HI = 1;
  localparam int OCFD_CTRL_ONOFF = 2;
  localparam logic [7:0] OCFD_CTRL_RESET = 8'h00;

  // fault register fields
  localparam int OCFD_F_SB = 0;
  localparam int OCFD_F_SBT = 1;
  localparam int OCFD_F_SG = 2;
  localparam int OCFD_F_OLOFF = 3;
  localparam int OCFD_F_OFFT = 4;
  localparam int OCFD_F_OLON = 5;

  // status register fields
  localparam int OCFD_S_OVL = 0;
  localparam int OCFD_S_FORCED = 1;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam logic [8:0] OCFD_PREDIV_128 = 9'h080;
  localparam logic [8:0] OCFD_PREDIV_192 = 9'h0C0;
  localparam logic [8:0] OCFD_PREDIV_256 = 9'h100;
  localparam logic [1:0] OCFD_TB_128 = 2'h0;
  localparam logic [1:0] OCFD_TB_256 = 2'h3;
  localparam logic [3:0] OCFD_NFAULT = 4'hA;
  localparam logic [6:0] OCFD_OLON_PERIODS = 7'h40;
  localparam logic [7:0] OCFD_RETRY_RESET = 8'h08;

  // filtered comparator flags travel together
  typedef struct packed {
    logic sb;
    logic sg;
    logic ol;
  } ocfd_flags_s;

  typedef enum logic [1:0] {OCFD_RUN, OCFD_FORCED_OFF} ocfd_drv_e;

  // predivider length from the two-bit timebase code
  function automatic logic [8:0] ocfd_prediv(input logic [1:0] sel);
    if (sel == OCFD_TB_128) begin
      ocfd_prediv = OCFD_PREDIV_128;
    end else if (sel == OCFD_TB_256) begin
      ocfd_prediv = OCFD_PREDIV_256;
    end else begin
      ocfd_prediv = OCFD_PREDIV_192;
    end
  endfunction
endpackage

// [ocfd_sync.sv]
// three-stage pin synchroniser with agreement check
module ocfd_sync import ocfd_pkg::*; (
  input wire logic i_clk, // system clock
  input wire logic i_reset, // synchronous reset
  input wire logic i_pin, // asynchronous pin level
  output logic o_level // qualified level
);
  logic s1_r, s2_r, s3_r;
  // ==========================================================================
  // capture chain; first stage is read only by the second
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // level only moves once two later stages agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_level <= 1'b0;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end
endmodule

// [ocfd_filt.sv]
// digital filter timer for one analog comparator flag
module ocfd_filt import ocfd_pkg::*; (
  input wire logic i_clk, // system clock
  input wire logic i_reset, // synchronous reset
  input wire logic i_raw, // synchronised raw flag
  input wire logic i_tick, // predivided tick
  input wire logic i_clr, // clear timer
  input wire logic i_hold, // force filtered flag low
  output logic o_filt // filtered flag
);
  logic [3:0] cnt_r;
  logic raw_d_r;
  // ==========================================================================
  // timer: restarts on raw rise, clears on raw fall or clear
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      raw_d_r <= 1'b0;
    end else begin
      raw_d_r <= i_raw;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset || i_clr || !i_raw || (i_raw && !raw_d_r)) begin
      cnt_r <= 4'h0;
    end else if (i_tick && cnt_r != OCFD_NFAULT) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // raw fall drops the flag at once, without waiting for the counter
  always_ff @(posedge i_clk) begin
    if (i_reset || i_hold || !i_raw || i_clr) begin
      o_filt <= 1'b0;
    end else if (cnt_r == OCFD_NFAULT) begin
      o_filt <= 1'b1;
    end
  end
endmodule

// [ocfd_top.sv]
// per-channel fault diagnostics: filters, tested timer, fault latches
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
module ocfd_top import ocfd_pkg::*; (
  input wire logic i_clk, // 20 MHz system clock
  input wire logic i_reset, // synchronous, active high
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  input wire logic i_pwm, // commanded gate level from control loop
  input wire logic i_pwm_period, // one pulse per pwm period start
  input wire logic i_short_batt_raw, // analog comparator pin
  input wire logic i_short_gnd_raw, // analog comparator pin
  input wire logic i_open_load_raw, // analog comparator pin
  input wire logic i_overvoltage, // battery over-voltage comparator pin
  output logic o_gate_drive_output, // gate drive to MOSFET
  output logic o_integrator_hold // freezes current integrator
);
  logic sb_s, sg_s, ol_s, ov_s;
  logic [7:0] ctrl_r;
  logic [7:0] retry_len_r;
  logic [8:0] pdiv_r;
  logic tick;
  logic gate_d_r;
  logic rise, fall;
  logic [3:0] tested_r;
  logic tested_exp;
  logic tested_hit;
  logic fault_rd;
  logic short_batt_fault_r, short_batt_tested_r, short_gnd_fault_r;
  logic open_load_off_fault_r, off_tested_r, open_load_on_fault_r;
  logic overvoltage_latch_flag_r;
  logic [6:0] hi_per_r;
  logic [7:0] retry_cnt_r;
  ocfd_drv_e drv_r;
  ocfd_flags_s filt;
  logic filt_clr;
  logic gate_nxt;

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  ocfd_sync u_sync_sb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_short_batt_raw),
    .o_level(sb_s)
  );
  ocfd_sync u_sync_sg (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_short_gnd_raw),
    .o_level(sg_s)
  );
  ocfd_sync u_sync_ol (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_open_load_raw),
    .o_level(ol_s)
  );
  ocfd_sync u_sync_ov (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_overvoltage),
    .o_level(ov_s)
  );

  // ==========================================================================
  // register bus
  // ==========================================================================
  // fault register read is the clearing event
  assign fault_rd = i_rd && (i_addr == OCFD_ADDR_FAULT);

  // control and retry length writes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= OCFD_CTRL_RESET;
      retry_len_r <= OCFD_RETRY_RESET;
    end else if (i_wr) begin
      if (i_addr == OCFD_ADDR_CTRL) begin
        ctrl_r <= i_wdata;
      end else if (i_addr == OCFD_ADDR_RETRY) begin
        retry_len_r <= i_wdata;
      end
    end
  end

  // read mux; returns pre-clear fault state, unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == OCFD_ADDR_CTRL) begin
        o_rdata <= ctrl_r;
      end else if (i_addr == OCFD_ADDR_FAULT) begin
        o_rdata <= {2'b00, open_load_on_fault_r, off_tested_r, open_load_off_fault_r,
                    short_gnd_fault_r, short_batt_tested_r, short_batt_fault_r};
      end else if (i_addr == OCFD_ADDR_STATUS) begin
        o_rdata <= {6'h00, (drv_r == OCFD_FORCED_OFF), overvoltage_latch_flag_r};
      end else if (i_addr == OCFD_ADDR_RETRY) begin
        o_rdata <= retry_len_r;
      end else begin
        o_rdata <= 8'h00;
      end
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // timebase predivider
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset || tick) begin
      pdiv_r <= 9'h000;
    end else begin
      pdiv_r <= pdiv_r + 9'h001;
    end
  end
  assign tick = (pdiv_r == ocfd_prediv({ctrl_r[OCFD_CTRL_TB_HI], ctrl_r[OCFD_CTRL_TB_LO]})
                 - 9'h001);

  // ==========================================================================
  // gate drive and edges
  // ==========================================================================
  // over-voltage and forced-off both win over the pwm command
  always_comb begin
    gate_nxt = i_pwm && !ov_s && (drv_r == OCFD_RUN);
    if (filt.sb && short_batt_tested_r) begin
      gate_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_gate_drive_output <= 1'b0;
      gate_d_r <= 1'b0;
      o_integrator_hold <= 1'b0;
    end else begin
      o_gate_drive_output <= gate_nxt;
      gate_d_r <= o_gate_drive_output;
      o_integrator_hold <= ov_s;
    end
  end
  assign rise = o_gate_drive_output && !gate_d_r;
  assign fall = !o_gate_drive_output && gate_d_r;
  assign filt_clr = rise || fall || fault_rd;

  // ==========================================================================
  // filter timers; sb held while low, sg/ol held while high
  // ==========================================================================
  ocfd_filt u_filt_sb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(sb_s),
    .i_tick(tick),
    .i_clr(filt_clr),
    .i_hold(!o_gate_drive_output),
    .o_filt(filt.sb)
  );
  ocfd_filt u_filt_sg (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(sg_s),
    .i_tick(tick),
    .i_clr(filt_clr),
    .i_hold(o_gate_drive_output),
    .o_filt(filt.sg)
  );
  ocfd_filt u_filt_ol (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(ol_s),
    .i_tick(tick),
    .i_clr(filt_clr),
    .i_hold(o_gate_drive_output),
    .o_filt(filt.ol)
  );

  // ==========================================================================
  // tested timer, shared by on- and off-state phases
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset || rise || fall || fault_rd) begin
      tested_r <= 4'h0;
    end else if (tick && !tested_exp) begin
      tested_r <= tested_r + 4'h1;
    end
  end
  assign tested_exp = (tested_r == OCFD_NFAULT);
  // expiry as a one-cycle event, so a later read really clears the tested bits
  assign tested_hit = tick && (tested_r == OCFD_NFAULT - 4'h1);

  // ==========================================================================
  // on-state latches; set beats read-clear
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      short_batt_tested_r <= 1'b0;
    end else if ((tested_hit && o_gate_drive_output)
                 || (filt.sb && short_batt_tested_r)) begin
      short_batt_tested_r <= 1'b1;
    end else if (fault_rd) begin
      short_batt_tested_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      short_batt_fault_r <= 1'b0;
    end else if (filt.sb && short_batt_tested_r) begin
      short_batt_fault_r <= 1'b1;
    end else if (fault_rd) begin
      short_batt_fault_r <= 1'b0;
    end
  end

  // high-period counter for on-state open load; restarts after a report
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_gate_drive_output || ctrl_r[OCFD_CTRL_ONOFF]) begin
      hi_per_r <= 7'h00;
    end else if (i_pwm_period) begin
      if (hi_per_r == OCFD_OLON_PERIODS - 7'h01) begin
        hi_per_r <= 7'h00;
      end else begin
        hi_per_r <= hi_per_r + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || ctrl_r[OCFD_CTRL_ONOFF]) begin
      open_load_on_fault_r <= 1'b0;
    end else if (o_gate_drive_output && i_pwm_period
                 && hi_per_r == OCFD_OLON_PERIODS - 7'h01) begin
      open_load_on_fault_r <= 1'b1;
    end else if (fault_rd) begin
      open_load_on_fault_r <= 1'b0;
    end
  end

  // ==========================================================================
  // off-state latches, active in both modes
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      off_tested_r <= 1'b0;
    end else if ((tested_hit && !o_gate_drive_output)
                 || (filt.sg && tested_exp)) begin
      off_tested_r <= 1'b1;
    end else if (fault_rd) begin
      off_tested_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      short_gnd_fault_r <= 1'b0;
    end else if (filt.sg && tested_exp) begin
      short_gnd_fault_r <= 1'b1;
    end else if (fault_rd) begin
      short_gnd_fault_r <= 1'b0;
    end
  end

  // ground short masks open load, which is left as it stands
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      open_load_off_fault_r <= 1'b0;
    end else if (!filt.sg && filt.ol) begin
      open_load_off_fault_r <= 1'b1;
    end else if (fault_rd) begin
      open_load_off_fault_r <= 1'b0;
    end
  end

  // ==========================================================================
  // over-voltage latch
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      overvoltage_latch_flag_r <= 1'b0;
    end else if (ov_s) begin
      overvoltage_latch_flag_r <= 1'b1;
    end else if (i_rd && i_addr == OCFD_ADDR_STATUS) begin
      overvoltage_latch_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // retry: forced off until retry_len pwm periods pass
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      drv_r <= OCFD_RUN;
      retry_cnt_r <= 8'h00;
    end else begin
      case (drv_r)
        OCFD_RUN: begin
          if (filt.sb && short_batt_tested_r) begin
            drv_r <= OCFD_FORCED_OFF;
            retry_cnt_r <= 8'h00;
          end
        end
        OCFD_FORCED_OFF: begin
          if (i_pwm_period) begin
            if (retry_cnt_r + 8'h01 >= retry_len_r) begin
              drv_r <= OCFD_RUN;
            end else begin
              retry_cnt_r <= retry_cnt_r + 8'h01;
            end
          end
        end
        default: begin
          drv_r <= OCFD_RUN;
        end
      endcase
    end
  end
endmodule

// [ocfd_checker.sv]
// port-level assertion checker for the fault diagnostics block
module ocfd_checker import ocfd_pkg::*; (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic [3:0] i_addr, // address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire logic i_pwm, // gate command
  input wire logic i_pwm_period, // period pulse
  input wire logic i_short_batt_raw, // comparator
  input wire logic i_short_gnd_raw, // comparator
  input wire logic i_open_load_raw, // comparator
  input wire logic i_overvoltage, // comparator
  input wire logic o_gate_drive_output, // gate
  input wire logic o_integrator_hold // integrator freeze
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ====
  // helpers
  // mirror of the on/off mode bit, kept from control writes
  logic mode_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_r <= 1'b0;
    end else if (i_wr && i_addr == OCFD_ADDR_CTRL) begin
      mode_r <= i_wdata[OCFD_CTRL_ONOFF];
    end
  end
  // six cycles covers the pin synchroniser with margin
  sequence s_ov_held; i_overvoltage [*6]; endsequence
  sequence s_fault_rd; i_rd && i_addr == OCFD_ADDR_FAULT; endsequence
  sequence s_stat_rd; i_rd && i_addr == OCFD_ADDR_STATUS; endsequence
  // ====
  // properties
  property p_ov_gate; s_ov_held |=> !o_gate_drive_output; endproperty
  property p_ov_hold; s_ov_held |=> o_integrator_hold; endproperty
  property p_hold_rel; !i_overvoltage [*6] |=> !o_integrator_hold; endproperty
  property p_gate_cmd; o_gate_drive_output |-> $past(i_pwm); endproperty
  property p_sb_pair; s_fault_rd ##1 o_rdata[OCFD_F_SB] |-> o_rdata[OCFD_F_SBT]; endproperty
  property p_sg_pair; s_fault_rd ##1 o_rdata[OCFD_F_SG] |-> o_rdata[OCFD_F_OFFT]; endproperty
  property p_onoff_olon; mode_r and s_fault_rd |=> !o_rdata[OCFD_F_OLON]; endproperty
  property p_fault_wid; s_fault_rd |=> o_rdata[7:6] == 2'h0; endproperty
  property p_stat_wid; s_stat_rd |=> o_rdata[7:2] == 6'h00; endproperty
  a_ov_gate: assert property (p_ov_gate) else $error("gate high in over-voltage");
  a_ov_hold: assert property (p_ov_hold) else $error("integrator not frozen");
  a_hold_rel: assert property (p_hold_rel) else $error("integrator stuck frozen");
  a_gate_cmd: assert property (p_gate_cmd) else $error("gate high without command");
  a_sb_pair: assert property (p_sb_pair) else $error("battery fault without tested");
  a_sg_pair: assert property (p_sg_pair) else $error("ground fault without tested");
  a_onoff_olon: assert property (p_onoff_olon) else $error("open load on in on/off");
  a_fault_wid: assert property (p_fault_wid) else $error("unused fault bits set");
  a_stat_wid: assert property (p_stat_wid) else $error("unused status bits set");
endmodule
bind ocfd_top ocfd_checker ocfd_checker_i (.i_clk(i_clk), .i_reset(i_reset),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_pwm(i_pwm), .i_pwm_period(i_pwm_period), .i_short_batt_raw(i_short_batt_raw),
  .i_short_gnd_raw(i_short_gnd_raw), .i_open_load_raw(i_open_load_raw),
  .i_overvoltage(i_overvoltage), .o_gate_drive_output(o_gate_drive_output),
  .o_integrator_hold(o_integrator_hold));

// [ocfd_load_model.sv]
// far-side model: load and comparators around the gate pin
module ocfd_load_model (
  input wire logic i_gate, // gate from device
  input wire logic i_sb_short, // drain shorted to battery
  input wire logic i_sg_short, // drain shorted to ground
  input wire logic i_open, // load disconnected
  output logic o_sb_raw, // battery short comparator
  output logic o_sg_raw, // ground short comparator
  output logic o_ol_raw // open load comparator
);
  timeunit 1ns;
  timeprecision 1ns;
  // battery short only shows while the switch conducts
  assign o_sb_raw = i_gate & i_sb_short;
  // off-state comparators run freely; masking while on is the device's job
  assign o_sg_raw = i_sg_short;
  assign o_ol_raw = i_open;
endmodule

// [test_ocfd_top.sv]
// self-checking bench for the fault diagnostics block
module test_ocfd_top import ocfd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 32; // clocks per pwm period
  localparam logic [7:0] SB = 8'h01 << OCFD_F_SB;
  localparam logic [7:0] SBT = 8'h01 << OCFD_F_SBT;
  localparam logic [7:0] SG = 8'h01 << OCFD_F_SG;
  localparam logic [7:0] OLOFF = 8'h01 << OCFD_F_OLOFF;
  localparam logic [7:0] OFFT = 8'h01 << OCFD_F_OFFT;
  localparam logic [7:0] OLON = 8'h01 << OCFD_F_OLON;
  localparam logic [7:0] ONOFF = 8'h01 << OCFD_CTRL_ONOFF;
  logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_pwm = 0, i_pwm_period = 0;
  logic i_overvoltage = 0, sb_c = 0, sg_c = 0, ol_c = 0, sbr, sgr, olr;
  logic o_gate_drive_output, o_integrator_hold;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, d;
  int fails = 0, samples_checked = 0, pc = 0, p;
  always #25 i_clk = ~i_clk;
  // one-clock period pulse every PER clocks
  always @(posedge i_clk) begin
    pc <= (pc == PER - 1) ? 0 : pc + 1;
    i_pwm_period <= (pc == 0);
  end
  ocfd_top ocfd_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm(i_pwm),
    .i_pwm_period(i_pwm_period), .i_short_batt_raw(sbr), .i_short_gnd_raw(sgr),
    .i_open_load_raw(olr), .i_overvoltage(i_overvoltage),
    .o_gate_drive_output(o_gate_drive_output), .o_integrator_hold(o_integrator_hold));
  ocfd_load_model ocfd_load_model_i (.i_gate(o_gate_drive_output), .i_sb_short(sb_c),
    .i_sg_short(sg_c), .i_open(ol_c), .o_sb_raw(sbr), .o_sg_raw(sgr), .o_ol_raw(olr));
  // ====
  // bus and check tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bounded wait on the gate level; a hang ends the run
  task automatic wait_gate(input logic lvl);
    int k;
    for (k = 0; k < 400 && o_gate_drive_output !== lvl; k++) @(posedge i_clk);
    if (k == 400) begin
      fails++;
      test_done();
    end
  endtask
  // ====
  // scenarios
  initial begin
    cyc(4);
    i_reset <= 1'b0;
    rdchk(OCFD_ADDR_CTRL, OCFD_CTRL_RESET);
    rdchk(OCFD_ADDR_RETRY, OCFD_RETRY_RESET);
    rdchk(OCFD_ADDR_STATUS, 8'h00);
    wr(OCFD_ADDR_FAULT, 8'hff);
    rdchk(OCFD_ADDR_FAULT, 8'h00);
    rdchk(4'h7, 8'h00);
    $display("test reset done");
    // off-state tested timer per timebase; each read restarts it
    for (int c = 0; c < 4; c++) begin
      p = (c == 0) ? 128 : (c == 3) ? 256 : 192;
      wr(OCFD_ADDR_CTRL, 8'(c));
      rd(OCFD_ADDR_FAULT);
      cyc(8 * p - 4);
      rdchk(OCFD_ADDR_FAULT, 8'h00);
      cyc(10 * p + 20);
      rdchk(OCFD_ADDR_FAULT, OFFT);
    end
    $display("test timebase done");
    wr(OCFD_ADDR_RETRY, 8'h02);
    wr(OCFD_ADDR_CTRL, ONOFF);
    i_pwm <= 1'b1;
    wait_gate(1'b1);
    rd(OCFD_ADDR_FAULT);
    cyc(8 * 128 - 4);
    rdchk(OCFD_ADDR_FAULT, 8'h00);
    cyc(1300);
    rdchk(OCFD_ADDR_FAULT, SBT);
    // a broken short restarts the filter, so no fault yet
    sb_c <= 1'b1;
    cyc(800);
    sb_c <= 1'b0;
    cyc(10);
    sb_c <= 1'b1;
    cyc(800);
    chk({7'h00, o_gate_drive_output}, 8'h01);
    // trip lands 1160 to 1300 clocks after the short; retry would reopen the gate
    cyc(300);
    wait_gate(1'b0);
    rdchk(OCFD_ADDR_STATUS, 8'h01 << OCFD_S_FORCED);
    sb_c <= 1'b0;
    rdchk(OCFD_ADDR_FAULT, SB | SBT);
    wait_gate(1'b1);
    rdchk(OCFD_ADDR_FAULT, 8'h00);
    $display("test battery short done");
    cyc(70 * PER);
    rdchk(OCFD_ADDR_FAULT, SBT);
    wr(OCFD_ADDR_CTRL, 8'h00);
    cyc(70 * PER);
    rdchk(OCFD_ADDR_FAULT, SBT | OLON);
    rdchk(OCFD_ADDR_FAULT, 8'h00);
    cyc(70 * PER);
    rdchk(OCFD_ADDR_FAULT, SBT | OLON);
    $display("test open load on done");
    // off-state comparators masked while the gate is on
    sg_c <= 1'b1;
    ol_c <= 1'b1;
    cyc(1500);
    rdchk(OCFD_ADDR_FAULT, SBT);
    wr(OCFD_ADDR_CTRL, ONOFF);
    i_pwm <= 1'b0;
    wait_gate(1'b0);
    cyc(1500);
    rdchk(OCFD_ADDR_FAULT, SG | OFFT);
    // short still stood at that read, so the set won; this read clears
    rdchk(OCFD_ADDR_FAULT, SG | OFFT);
    sg_c <= 1'b0;
    cyc(1500);
    rdchk(OCFD_ADDR_FAULT, OLOFF | OFFT);
    ol_c <= 1'b0;
    cyc(20);
    rdchk(OCFD_ADDR_FAULT, OLOFF);
    rdchk(OCFD_ADDR_FAULT, 8'h00);
    $display("test off-state done");
    i_pwm <= 1'b1;
    wait_gate(1'b1);
    i_overvoltage <= 1'b1;
    cyc(10);
    chk({6'h00, o_integrator_hold, o_gate_drive_output}, 8'h02);
    rdchk(OCFD_ADDR_STATUS, 8'h01 << OCFD_S_OVL);
    i_overvoltage <= 1'b0;
    cyc(10);
    rdchk(OCFD_ADDR_STATUS, 8'h01 << OCFD_S_OVL);
    rdchk(OCFD_ADDR_STATUS, 8'h00);
    wait_gate(1'b1);
    $display("test over-voltage done");
    test_done();
  end
endmodule
